/* File: rtl/spc_pkg.sv */
// Shared constants and types of the sample path configuration block
package spc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RATE_DIVIDER_OFFSET  = 8'h19; // Sample rate divider
	localparam logic [7:0] SAMPLE_PATH_OFFSET   = 8'h1A; // Sample path configuration
	localparam logic [7:0] ACCEL_RANGE_OFFSET   = 8'h1C; // Range and self-test
	localparam logic [7:0] FILTER_BYPASS_OFFSET = 8'h30; // Filter bypass select bits
	localparam logic [7:0] PATH_STATUS_OFFSET   = 8'h31; // Block status, read only

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00; // All writable registers

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FULL_POLICY_BIT  = 6; // 1 discard new, 0 overwrite oldest
	localparam int SYNC_SEL_LSB     = 3; // Sync tag select [5:3]
	localparam int SYNC_SEL_MSB     = 5;
	localparam int LOWPASS_LSB      = 0; // Lowpass setting [2:0]
	localparam int LOWPASS_MSB      = 2;
	localparam int X_SELFTEST_BIT   = 7;
	localparam int Y_SELFTEST_BIT   = 6;
	localparam int Z_SELFTEST_BIT   = 5;
	localparam int RANGE_LSB        = 3; // Accel range select [4:3]
	localparam int RANGE_MSB        = 4;
	localparam int BYPASS_LSB       = 0; // Filter bypass select [1:0]
	localparam int BYPASS_MSB       = 1;
	localparam int STAT_OVERFLOW    = 0; // Sticky, read clears
	localparam int STAT_SYNC_LATCH  = 1; // Latched frame sync
	localparam int STAT_SYNC_ARMED  = 2; // Latch armed
	localparam int STAT_SYNC_TAG    = 3; // Last captured tag
	localparam int STAT_LOWPASS_ON  = 4; // Lowpass setting in effect
	localparam int STAT_DIVIDER_ON  = 5; // Rate divider in effect

	// ----------------------------------------------------------------
	// Sync tag select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SYNC_OFF    = 3'h0;
	localparam logic [2:0] SYNC_TEMP   = 3'h1;
	localparam logic [2:0] SYNC_ACCELX = 3'h5;
	localparam logic [2:0] SYNC_ACCELY = 3'h6;
	localparam logic [2:0] SYNC_ACCELZ = 3'h7;

	// ----------------------------------------------------------------
	// Lowpass codes and temperature bandwidths in Hz
	// ----------------------------------------------------------------
	localparam logic [2:0]  LOWPASS_MIN = 3'h1; // Lowest filtering code
	localparam logic [2:0]  LOWPASS_MAX = 3'h6; // Highest filtering code
	localparam logic [12:0] BW_WIDE     = 13'h0FA0; // 4000 Hz
	localparam logic [12:0] BW_CODE1    = 13'h00BC; // 188 Hz
	localparam logic [12:0] BW_CODE2    = 13'h0062; // 98 Hz
	localparam logic [12:0] BW_CODE3    = 13'h002A; // 42 Hz
	localparam logic [12:0] BW_CODE4    = 13'h0014; // 20 Hz
	localparam logic [12:0] BW_CODE5    = 13'h000A; // 10 Hz
	localparam logic [12:0] BW_CODE6    = 13'h0005; // 5 Hz

	// ----------------------------------------------------------------
	// Full scale in g per range code
	// ----------------------------------------------------------------
	localparam logic [4:0] RANGE_2G  = 5'h02;
	localparam logic [4:0] RANGE_4G  = 5'h04;
	localparam logic [4:0] RANGE_8G  = 5'h08;
	localparam logic [4:0] RANGE_16G = 5'h10;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ         = 200000000; // System clock rate
	localparam int INTERNAL_RATE_HZ = 1000;      // Internal sample rate
	localparam int TICK_CYCLES      = CLOCK_HZ / INTERNAL_RATE_HZ;

	// Overflow handling taken for one sample
	typedef enum logic [1:0] {FIFO_PLAIN, FIFO_OVERWRITE, FIFO_DISCARD} spc_fifo_act_t;

endpackage : spc_pkg

/* File: rtl/spc_rate_strobe.sv */
// Internal rate tick and divided sample-rate strobe
`timescale 1ns/1ps
module spc_rate_strobe #(
	parameter int TICK_CYCLES = spc_pkg::TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] divValue,
	input  wire logic       divEnable,
	output logic            sampleStrobe
);

	localparam int CW = $clog2(TICK_CYCLES);
	localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] tickCnt_r;  // Clock cycles within one internal period
	logic [7:0]    sampleCnt_r; // Internal ticks since the last strobe
	logic          tick;        // One-cycle internal rate enable

	assign tick = (tickCnt_r == TICK_LAST);

	// Internal rate divider from the system clock
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tickCnt_r <= '0;
		else if (tick)
			tickCnt_r <= '0;
		else
			tickCnt_r <= tickCnt_r + 1'b1;
	end

	// Strobe every tick, or every (1 + divider) ticks when it applies
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sampleCnt_r  <= 8'h00;
			sampleStrobe <= 1'b0;
		end
		else
		begin
			sampleStrobe <= 1'b0;
			if (tick)
			begin
				if (!divEnable || sampleCnt_r >= divValue)
				begin
					sampleCnt_r  <= 8'h00;
					sampleStrobe <= 1'b1;
				end
				else
					sampleCnt_r <= sampleCnt_r + 8'h01;
			end
		end
	end

endmodule : spc_rate_strobe

/* File: rtl/spc_sync_latch.sv */
// Frame sync latch that holds one toggle until a sample strobe takes it
`timescale 1ns/1ps
module spc_sync_latch (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic frameSyncInput,
	input  wire logic sampleStrobe,
	output logic      syncLatched_r,
	output logic      syncArmed_r,
	output logic      syncTag_r
);

	// Follow one toggle, freeze until a strobe captures it
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			syncLatched_r <= 1'b0;
			syncArmed_r   <= 1'b1;
			syncTag_r     <= 1'b0;
		end
		else
		begin
			if (sampleStrobe)
				syncTag_r <= syncLatched_r;
			if (syncArmed_r && frameSyncInput != syncLatched_r)
			begin
				syncLatched_r <= frameSyncInput;
				syncArmed_r   <= 1'b0;
			end
			else if (sampleStrobe)
				syncArmed_r <= 1'b1;
		end
	end

endmodule : spc_sync_latch

/* File: rtl/spc_sample_path.sv */
// Sample path configuration: registers, sync tagging, overflow policy
//
// Notes on behaviour
// - Full FIFO: policy 1 discards, 0 overwrites
// - Tag select puts sync into chosen bit0
// - Latched sync toggles once until strobe capture
// - Lowpass setting used only when bypass zero
// - Temperature bandwidth follows bypass and lowpass
// - Range code maps to 2,4,8,16 g
// - Strobe is 1 kHz over one plus divider while bypass is zero and lowpass code is 1 to 6, else 1 kHz
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module spc_sample_path #(
	parameter int TICK_CYCLES = spc_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData_r,
	// Sensor data and frame sync
	input  wire logic        frameSyncInput,
	input  wire logic [7:0]  tempLowIn,
	input  wire logic [7:0]  accelXLowIn,
	input  wire logic [7:0]  accelYLowIn,
	input  wire logic [7:0]  accelZLowIn,
	// FIFO side
	input  wire logic        fifoFull,
	output logic             fifoWrite_r,
	output logic             fifoDropOldest_r,
	// Sample outputs
	output logic             sampleStrobe_r,
	output logic      [7:0]  tempLowOut_r,
	output logic      [7:0]  accelXLowOut_r,
	output logic      [7:0]  accelYLowOut_r,
	output logic      [7:0]  accelZLowOut_r,
	// Configuration outputs
	output logic      [12:0] tempBandwidthHz_r,
	output logic      [2:0]  lowpassApplied_r,
	output logic             lowpassActive_r,
	output logic      [4:0]  accelRangeG_r,
	output logic             xAxisSelftest_r,
	output logic             yAxisSelftest_r,
	output logic             zAxisSelftest_r
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Temperature bandwidth for bypass bits and lowpass code
	function automatic logic [12:0] spc_temp_bw(input logic [1:0] bypass,
		input logic [2:0] code);
		logic [12:0] bw;
		bw = spc_pkg::BW_WIDE;
		if (bypass == 2'h0)
		begin
			case (code)
				3'h1:    bw = spc_pkg::BW_CODE1;
				3'h2:    bw = spc_pkg::BW_CODE2;
				3'h3:    bw = spc_pkg::BW_CODE3;
				3'h4:    bw = spc_pkg::BW_CODE4;
				3'h5:    bw = spc_pkg::BW_CODE5;
				3'h6:    bw = spc_pkg::BW_CODE6;
				default: bw = spc_pkg::BW_WIDE; // Codes 0 and 7 stay wide
			endcase
		end
		return bw;
	endfunction : spc_temp_bw

	// Full scale in g for the range code
	function automatic logic [4:0] spc_range_g(input logic [1:0] code);
		logic [4:0] g;
		case (code)
			2'h0:    g = spc_pkg::RANGE_2G;
			2'h1:    g = spc_pkg::RANGE_4G;
			2'h2:    g = spc_pkg::RANGE_8G;
			default: g = spc_pkg::RANGE_16G;
		endcase
		return g;
	endfunction : spc_range_g

	// Low byte with bit 0 replaced when this byte is the chosen one
	function automatic logic [7:0] spc_tag(input logic [7:0] data,
		input logic hit, input logic tag);
		return hit ? {data[7:1], tag} : data;
	endfunction : spc_tag

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	logic [7:0] rateDivider_r;  // Sample rate divider
	logic [7:0] samplePath_r;   // Policy, tag select, lowpass setting
	logic [7:0] accelRange_r;   // Self-test bits and range code
	logic [1:0] filterBypass_r; // Filter bypass select bits
	logic       overflowSeen_r; // Sticky FIFO full event

	logic [2:0] syncSelect;     // Sync tag select field
	logic [2:0] lowpassSetting; // Lowpass setting field
	logic       lowpassOn;      // Setting applies
	logic       dividerOn;      // Divider applies
	logic       sampleStrobe;   // Strobe from the rate divider
	logic       syncLatched;    // Latch state
	logic       syncArmed;      // Latch free to follow
	logic       syncTag;        // Value taken by the strobe
	logic       statusRead;     // Read of the status register
	logic       overflowEvent;  // Sample met a full FIFO
	logic [7:0] statusWord;     // Assembled status
	spc_pkg::spc_fifo_act_t fifoAct; // Handling of this sample

	assign syncSelect     = samplePath_r[spc_pkg::SYNC_SEL_MSB:spc_pkg::SYNC_SEL_LSB];
	assign lowpassSetting = samplePath_r[spc_pkg::LOWPASS_MSB:spc_pkg::LOWPASS_LSB];
	assign lowpassOn      = (filterBypass_r == 2'h0);
	assign dividerOn      = lowpassOn && lowpassSetting >= spc_pkg::LOWPASS_MIN
		&& lowpassSetting <= spc_pkg::LOWPASS_MAX;
	assign statusRead     = regRead && regAddr == spc_pkg::PATH_STATUS_OFFSET;

	// Software writes; reserved bits of the path and range registers are stored as
	// written (bypass keeps only [1:0]) and are the host's to keep at zero, they steer nothing here
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rateDivider_r  <= spc_pkg::REG_RESET;
			samplePath_r   <= spc_pkg::REG_RESET;
			accelRange_r   <= spc_pkg::REG_RESET;
			filterBypass_r <= 2'h0;
		end
		else if (regWrite)
		begin
			if (regAddr == spc_pkg::RATE_DIVIDER_OFFSET)
				rateDivider_r <= regWrData;
			else if (regAddr == spc_pkg::SAMPLE_PATH_OFFSET)
				samplePath_r <= regWrData;
			else if (regAddr == spc_pkg::ACCEL_RANGE_OFFSET)
				accelRange_r <= regWrData;
			else if (regAddr == spc_pkg::FILTER_BYPASS_OFFSET)
				filterBypass_r <= regWrData[spc_pkg::BYPASS_MSB:spc_pkg::BYPASS_LSB];
		end
	end

	// Status word, unused bits read zero
	always_comb
	begin
		statusWord = 8'h00;
		statusWord[spc_pkg::STAT_OVERFLOW]   = overflowSeen_r;
		statusWord[spc_pkg::STAT_SYNC_LATCH] = syncLatched;
		statusWord[spc_pkg::STAT_SYNC_ARMED] = syncArmed;
		statusWord[spc_pkg::STAT_SYNC_TAG]   = syncTag;
		statusWord[spc_pkg::STAT_LOWPASS_ON] = lowpassOn;
		statusWord[spc_pkg::STAT_DIVIDER_ON] = dividerOn;
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			regRdData_r <= 8'h00;
		else if (!regRead)
			regRdData_r <= 8'h00;
		else if (regAddr == spc_pkg::RATE_DIVIDER_OFFSET)
			regRdData_r <= rateDivider_r;
		else if (regAddr == spc_pkg::SAMPLE_PATH_OFFSET)
			regRdData_r <= samplePath_r;
		else if (regAddr == spc_pkg::ACCEL_RANGE_OFFSET)
			regRdData_r <= accelRange_r;
		else if (regAddr == spc_pkg::FILTER_BYPASS_OFFSET)
			regRdData_r <= {6'h00, filterBypass_r};
		else if (regAddr == spc_pkg::PATH_STATUS_OFFSET)
			regRdData_r <= statusWord;
		else
			regRdData_r <= 8'h00; // Unmapped address
	end

	// Sticky overflow; a new event beats the clear of a status read
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			overflowSeen_r <= 1'b0;
		else if (overflowEvent)
			overflowSeen_r <= 1'b1;
		else if (statusRead)
			overflowSeen_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Rate strobe and frame sync latch
	// ----------------------------------------------------------------
	spc_rate_strobe #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_rate (
		.clk          (clk),
		.reset        (reset),
		.divValue     (rateDivider_r),
		.divEnable    (dividerOn),
		.sampleStrobe (sampleStrobe)
	);

	spc_sync_latch u_sync (
		.clk            (clk),
		.reset          (reset),
		.frameSyncInput (frameSyncInput),
		.sampleStrobe   (sampleStrobe),
		.syncLatched_r  (syncLatched),
		.syncArmed_r    (syncArmed),
		.syncTag_r      (syncTag)
	);

	// ----------------------------------------------------------------
	// Sample capture and FIFO policy
	// ----------------------------------------------------------------

	// Choose overflow handling; the FIFO itself moves the data
	always_comb
	begin
		fifoAct = spc_pkg::FIFO_PLAIN;
		if (fifoFull && samplePath_r[spc_pkg::FULL_POLICY_BIT])
			fifoAct = spc_pkg::FIFO_DISCARD;
		else if (fifoFull)
			fifoAct = spc_pkg::FIFO_OVERWRITE;
	end

	assign overflowEvent = sampleStrobe_r && fifoFull;

	// Capture one cycle after the strobe, once the tag has settled
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sampleStrobe_r <= 1'b0;
			tempLowOut_r   <= 8'h00;
			accelXLowOut_r <= 8'h00;
			accelYLowOut_r <= 8'h00;
			accelZLowOut_r <= 8'h00;
		end
		else
		begin
			sampleStrobe_r <= sampleStrobe;
			if (sampleStrobe_r)
			begin
				tempLowOut_r   <= spc_tag(tempLowIn,
					syncSelect == spc_pkg::SYNC_TEMP, syncTag);
				accelXLowOut_r <= spc_tag(accelXLowIn,
					syncSelect == spc_pkg::SYNC_ACCELX, syncTag);
				accelYLowOut_r <= spc_tag(accelYLowIn,
					syncSelect == spc_pkg::SYNC_ACCELY, syncTag);
				accelZLowOut_r <= spc_tag(accelZLowIn,
					syncSelect == spc_pkg::SYNC_ACCELZ, syncTag);
			end
		end
	end

	// FIFO pulses beside the captured bytes
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fifoWrite_r      <= 1'b0;
			fifoDropOldest_r <= 1'b0;
		end
		else
		begin
			fifoWrite_r      <= sampleStrobe_r && fifoAct != spc_pkg::FIFO_DISCARD;
			fifoDropOldest_r <= sampleStrobe_r && fifoAct == spc_pkg::FIFO_OVERWRITE;
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------

	// Filter and range decode held in flops
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tempBandwidthHz_r <= spc_pkg::BW_WIDE;
			lowpassApplied_r  <= 3'h0;
			lowpassActive_r   <= 1'b1;
			accelRangeG_r     <= spc_pkg::RANGE_2G;
			xAxisSelftest_r   <= 1'b0;
			yAxisSelftest_r   <= 1'b0;
			zAxisSelftest_r   <= 1'b0;
		end
		else
		begin
			tempBandwidthHz_r <= spc_temp_bw(filterBypass_r, lowpassSetting);
			lowpassApplied_r  <= lowpassOn ? lowpassSetting : 3'h0;
			lowpassActive_r   <= lowpassOn;
			accelRangeG_r     <= spc_range_g(
				accelRange_r[spc_pkg::RANGE_MSB:spc_pkg::RANGE_LSB]);
			xAxisSelftest_r   <= accelRange_r[spc_pkg::X_SELFTEST_BIT];
			yAxisSelftest_r   <= accelRange_r[spc_pkg::Y_SELFTEST_BIT];
			zAxisSelftest_r   <= accelRange_r[spc_pkg::Z_SELFTEST_BIT];
		end
	end

endmodule : spc_sample_path

/* File: tb/spc_sample_path_monitor.sv */
// Port checker of the sample path configuration block
`timescale 1ns/1ps
module spc_sample_path_monitor #(
	parameter int TICK_CYCLES = spc_pkg::TICK_CYCLES
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regRdData_r,
	input wire logic [7:0]  tempLowIn,
	input wire logic        fifoFull,
	input wire logic        fifoWrite_r,
	input wire logic        fifoDropOldest_r,
	input wire logic        sampleStrobe_r,
	input wire logic [7:0]  tempLowOut_r,
	input wire logic [12:0] tempBandwidthHz_r,
	input wire logic [2:0]  lowpassApplied_r,
	input wire logic        lowpassActive_r,
	input wire logic [4:0]  accelRangeG_r
);
	// --------
	// Shadow state
	// --------
	localparam logic [12:0] BW [8] = '{13'h0FA0, 13'h00BC, 13'h0062, 13'h002A,
		13'h0014, 13'h000A, 13'h0005, 13'h0FA0}; // Hz per lowpass code
	logic [7:0]  path_r;   // Path register
	logic [7:0]  range_r;  // Range register
	logic [1:0]  bypass_r; // Bypass bits
	logic [7:0]  div_r;    // Rate divider
	logic        wrPrev_r; // Write one cycle ago
	logic [15:0] gap_r;    // Cycles since last strobe
	logic [1:0]  dirty_r;  // Strobes to skip after a write
	logic        seen_r;   // A strobe has passed
	logic        quiet;    // No write now or one cycle ago
	logic [15:0] period;   // Expected strobe spacing

	assign quiet = !regWrite && !wrPrev_r;
	// Divider counts only while the filter is in use
	assign period = (bypass_r == 2'b00 && path_r[2:0] inside {[3'h1:3'h6]})
		? ({8'h00, div_r} + 16'h0001) * 16'(TICK_CYCLES) : 16'(TICK_CYCLES);

	// Mirror host writes
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			path_r   <= 8'h00;
			range_r  <= 8'h00;
			bypass_r <= 2'h0;
			div_r    <= 8'h00;
		end
		else if (regWrite)
		begin
			if (regAddr == spc_pkg::SAMPLE_PATH_OFFSET)
				path_r <= regWrData;
			if (regAddr == spc_pkg::ACCEL_RANGE_OFFSET)
				range_r <= regWrData;
			if (regAddr == spc_pkg::FILTER_BYPASS_OFFSET)
				bypass_r <= regWrData[1:0];
			if (regAddr == spc_pkg::RATE_DIVIDER_OFFSET)
				div_r <= regWrData;
		end
	end

	// Spacing; skip two strobes after a write, the divider may restart
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wrPrev_r <= 1'b0;
			gap_r    <= 16'h0000;
			dirty_r  <= 2'h0;
			seen_r   <= 1'b0;
		end
		else
		begin
			wrPrev_r <= regWrite;
			gap_r    <= sampleStrobe_r ? 16'h0001 : gap_r + {15'h0000, gap_r != 16'hFFFF};
			dirty_r  <= regWrite ? 2'h2 : dirty_r - {1'b0, sampleStrobe_r && dirty_r != 2'h0};
			seen_r   <= seen_r | sampleStrobe_r;
		end
	end

	// --------
	// Assertions
	// --------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_full_discard:
	assert property (sampleStrobe_r && fifoFull && quiet && path_r[6] |=> !fifoWrite_r)
		else $error("write under discard");
	a_full_overwrite:
	assert property (sampleStrobe_r && fifoFull && quiet && !path_r[6]
		|=> fifoWrite_r && fifoDropOldest_r) else $error("full fifo not overwritten");
	a_plain_push:
	assert property (sampleStrobe_r && !fifoFull |=> fifoWrite_r && !fifoDropOldest_r)
		else $error("sample not pushed");
	a_push_follows_strobe:
	assert property (!$past(sampleStrobe_r) |-> !fifoWrite_r)
		else $error("fifo push without sample");
	a_temp_untagged:
	assert property (sampleStrobe_r && quiet && $stable(tempLowIn) && path_r[5:3] != 3'h1
		|=> tempLowOut_r == $past(tempLowIn)) else $error("temp byte altered");
	a_lowpass_gate:
	assert property (quiet |-> lowpassActive_r == (bypass_r == 2'b00)
		&& lowpassApplied_r == (bypass_r == 2'b00 ? path_r[2:0] : 3'h0))
		else $error("lowpass used in bypass");
	a_temp_bandwidth:
	assert property (quiet |-> tempBandwidthHz_r == (bypass_r != 2'b00 ? 13'h0FA0
		: BW[path_r[2:0]])) else $error("wrong temp bandwidth");
	a_range_map:
	assert property (quiet |-> accelRangeG_r == (5'h02 << range_r[4:3]))
		else $error("wrong full scale");
	a_range_readback:
	assert property (regRead && regAddr == spc_pkg::ACCEL_RANGE_OFFSET
		|=> regRdData_r == $past(range_r)) else $error("range register readback");
	a_strobe_period:
	assert property (sampleStrobe_r && seen_r && dirty_r == 2'h0 |-> gap_r == period)
		else $error("strobe spacing off");
	a_strobe_overdue:
	assert property (seen_r && dirty_r == 2'h0 |-> gap_r <= period)
		else $error("strobe overdue");
	a_read_idle:
	assert property (!$past(regRead) |-> regRdData_r == 8'h00)
		else $error("stray read data");

	c_discard: cover property (sampleStrobe_r && fifoFull && path_r[6]);
	c_overwrite: cover property (sampleStrobe_r && fifoFull && !path_r[6]);
	c_divided: cover property (sampleStrobe_r && dirty_r == 2'h0 && period > 16'(TICK_CYCLES));
endmodule : spc_sample_path_monitor

bind spc_sample_path spc_sample_path_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (.*);

/* File: tb/spc_host_model.sv */
// Host processor model driving the register port
`timescale 1ns/1ps
module spc_host_model (
	input  wire logic       clk,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrite,
	output logic            regRead,
	input  wire logic [7:0] regRdData_r
);
	// Bus idle from time zero
	initial
	begin
		regAddr   = 8'h00;
		regWrData = 8'h00;
		regWrite  = 1'b0;
		regRead   = 1'b0;
	end

	// Write; reserved bits of the path and range registers sent as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = (a == spc_pkg::SAMPLE_PATH_OFFSET) ? 8'h7F :
			(a == spc_pkg::ACCEL_RANGE_OFFSET) ? 8'hF8 : 8'hFF;
		@(posedge clk);
		regAddr   <= a;
		regWrData <= d & m;
		regWrite  <= 1'b1;
		@(posedge clk);
		regWrite  <= 1'b0;
	endtask : wr

	// Read; data taken in the next cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		d = regRdData_r;
	endtask : rd
endmodule : spc_host_model

/* File: tb/spc_sample_path_tb.sv */
// Self-checking testbench of the sample path configuration block
`timescale 1ns/1ps
module spc_sample_path_tb;
	localparam int TICK = 8; // Short tick, brief run
	localparam logic [7:0] LP_TAB [4] = '{8'h01, 8'h06, 8'h07, 8'h03};

	logic        clk;            // System clock
	logic        reset;          // Asynchronous reset
	logic [7:0]  regAddr;        // Register port, host side
	logic [7:0]  regWrData;
	logic        regWrite;
	logic        regRead;
	logic [7:0]  regRdData;
	logic        frameSyncInput; // Frame sync level
	logic [7:0]  rawIn [4];      // Temp, X, Y, Z raw low bytes
	logic [7:0]  outB [4];       // Same bytes after tagging
	logic        fifoFull;       // Full flag of the outside FIFO
	logic        fifoWr;
	logic        fifoDrop;
	logic        strobe;
	logic [12:0] bw;
	logic [2:0]  lpApplied;
	logic        lpActive;
	logic [4:0]  rangeG;
	logic [2:0]  st;             // Self-test bits X, Y, Z
	logic [7:0]  rdv;            // Last read data
	logic [7:0]  v;
	logic        s;
	int          p;
	int          n_errors;
	int          num_checks;

	spc_sample_path #(.TICK_CYCLES(TICK)) u_spc_sample_path (.*, .regRdData_r(regRdData),
		.tempLowIn(rawIn[0]), .accelXLowIn(rawIn[1]), .accelYLowIn(rawIn[2]),
		.accelZLowIn(rawIn[3]), .fifoWrite_r(fifoWr), .fifoDropOldest_r(fifoDrop),
		.sampleStrobe_r(strobe), .tempLowOut_r(outB[0]), .accelXLowOut_r(outB[1]),
		.accelYLowOut_r(outB[2]), .accelZLowOut_r(outB[3]), .tempBandwidthHz_r(bw),
		.lowpassApplied_r(lpApplied), .lowpassActive_r(lpActive), .accelRangeG_r(rangeG),
		.xAxisSelftest_r(st[2]), .yAxisSelftest_r(st[1]), .zAxisSelftest_r(st[0]));

	spc_host_model u_host (.*, .regRdData_r(regRdData));

	// --------
	// Helpers
	// --------
	// Compare value with expectation
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Verdict and end of run
	task automatic end_of_test;
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// Byte k tagged with t under code c
	function automatic logic [7:0] tagExp(input logic [2:0] c, input int k,
		input logic [7:0] b, input logic t);
		logic hit;
		hit = (c == 3'h1 && k == 0) || (c >= 3'h5 && k == int'(c) - 4);
		return hit ? {b[7:1], t} : b;
	endfunction : tagExp

	// Bandwidth in Hz
	function automatic logic [12:0] bwExp(input logic [1:0] b, input logic [2:0] l);
		logic [12:0] t [8];
		t = '{13'h0FA0, 13'h00BC, 13'h0062, 13'h002A, 13'h0014, 13'h000A, 13'h0005, 13'h0FA0};
		return (b != 2'b00) ? 13'h0FA0 : t[l];
	endfunction : bwExp

	// New raw bytes and sync level
	task automatic setIn(input logic t);
		@(posedge clk);
		foreach (rawIn[k])
			rawIn[k] <= 8'($urandom);
		frameSyncInput <= t;
	endtask : setIn

	// Wait for a strobe and its sample
	task automatic getSample;
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (strobe !== 1'b1 && n < 3000);
		chk("strobe seen", 1'b1, strobe);
		@(negedge clk);
	endtask : getSample

	// Strobe spacing
	task automatic measure(output int q);
		getSample;
		q = 1;
		while (strobe !== 1'b1 && q < 3000)
		begin
			@(negedge clk);
			q++;
		end
	endtask : measure

	// --------
	// Clock, watchdog and sequence
	// --------
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Ample margin
	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		end_of_test;
	end

	initial
	begin
		n_errors = 0;
		num_checks = 0;
		void'($urandom(32'hA1D6ADED));
		reset = 1'b1;
		frameSyncInput = 1'b0;
		fifoFull = 1'b0;
		rawIn = '{default: 8'h00};
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Reset state and an unmapped address
		u_host.rd(spc_pkg::SAMPLE_PATH_OFFSET, rdv);
		chk("path reg reset", 8'h00, rdv);
		chk("reset bandwidth", 13'h0FA0, bw);
		chk("reset range", 5'h02, rangeG);
		chk("reset lowpass on", 1'b1, lpActive);
		u_host.wr(8'h55, 8'hA5);
		u_host.rd(8'h55, rdv);
		chk("unmapped read", 8'h00, rdv);
		// All range codes
		for (int r = 0; r < 4; r++)
		begin
			v = 8'($urandom);
			v[4:3] = r[1:0];
			u_host.wr(spc_pkg::ACCEL_RANGE_OFFSET, v);
			repeat (2) @(negedge clk);
			chk("range g", 5'h02 << r, rangeG);
			chk("selftest bits", v[7:5], st);
			u_host.rd(spc_pkg::ACCEL_RANGE_OFFSET, rdv);
			chk("range readback", v & 8'hF8, rdv);
		end
		// All bypass and lowpass pairs
		for (int b = 0; b < 4; b++)
			for (int l = 0; l < 8; l++)
			begin
				u_host.wr(spc_pkg::FILTER_BYPASS_OFFSET, 8'(b));
				u_host.wr(spc_pkg::SAMPLE_PATH_OFFSET, 8'(l));
				repeat (2) @(negedge clk);
				chk("temp bandwidth", bwExp(b[1:0], l[2:0]), bw);
				chk("lowpass applied", b == 0 ? 3'(l) : 3'h0, lpApplied);
				chk("lowpass on", b == 0, lpActive);
			end
		// All sync select codes
		u_host.wr(spc_pkg::FILTER_BYPASS_OFFSET, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			s = 1'($urandom);
			u_host.wr(spc_pkg::SAMPLE_PATH_OFFSET, 8'(c << 3) | 8'h81);
			setIn(s);
			getSample;
			getSample;
			for (int k = 0; k < 4; k++)
				chk("tagged byte", tagExp(3'(c), k, rawIn[k], s), outB[k]);
			chk("plain push", 2'b10, {fifoWr, fifoDrop});
		end
		// Short sync pulse held to the strobe
		u_host.wr(spc_pkg::SAMPLE_PATH_OFFSET, 8'h28);
		setIn(1'b0);
		getSample;
		getSample;
		@(posedge clk);
		frameSyncInput <= 1'b1;
		@(posedge clk);
		frameSyncInput <= 1'b0;
		getSample;
		chk("held sync pulse", 1'b1, outB[1][0]);
		getSample;
		chk("sync after capture", 1'b0, outB[1][0]);
		// Full FIFO under both policies
		@(posedge clk);
		fifoFull <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			u_host.wr(spc_pkg::SAMPLE_PATH_OFFSET, 8'(m << 6));
			getSample;
			getSample;
			chk("full fifo action", m == 1 ? 2'b00 : 2'b11, {fifoWr, fifoDrop});
		end
		@(posedge clk);
		fifoFull <= 1'b0;
		u_host.rd(spc_pkg::PATH_STATUS_OFFSET, rdv);
		chk("overflow flag", 1'b1, rdv[0]);
		// Divider only with filtering in use
		for (int t = 0; t < 4; t++)
		begin
			v = 8'($urandom_range(3, 1));
			u_host.wr(spc_pkg::RATE_DIVIDER_OFFSET, v);
			u_host.wr(spc_pkg::FILTER_BYPASS_OFFSET, 8'(t == 3));
			u_host.wr(spc_pkg::SAMPLE_PATH_OFFSET, LP_TAB[t]);
			getSample;
			measure(p);
			chk("strobe period", t < 2 ? (v + 16'h1) * TICK : TICK, 16'(p));
		end
		end_of_test;
	end
endmodule : spc_sample_path_tb
